// ==== inc/uart_rx_map.vh ====
// Register map, field positions and constants of the serial receive buffer block.
`ifndef UART_RX_MAP_VH
`define UART_RX_MAP_VH

`define ADDR_W 4
`define ADDR_DATA 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_CONTROL 4'h8
`define ADDR_FORMAT 4'hC

`define ST_RXC 7
`define ST_FE 4
`define ST_DOR 3
`define ST_UPE 2

`define CT_IRQ_EN 7
`define CT_RX_EN 4
`define CT_NINTH 1

`define FMT_PAR_EN 5
`define FMT_PAR_ODD 4
`define FMT_STOP_SEL 3
`define FMT_SIZE_HI 2
`define FMT_SIZE_LO 0

`define SIZE_NINE 3'h7
`define SIZE_RESET 3'h3
`define SIZE_BASE 4'h5
`define BITS_MAX 4'h9

`define ENT_W 12
`define ENT_DOR 11
`define ENT_FE 10
`define ENT_UPE 9
`define ENT_NINTH 8
`define FIFO_DEPTH 2'h2

`endif

// ==== design/rx_frame_fifo.v ====
// Two-entry frame buffer holding data, ninth bit and error flags per frame.
`timescale 1ns/1ns
`include "uart_rx_map.vh"
module rx_frame_fifo (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Control
  input wire flush,
  input wire push,
  input wire [`ENT_W-1:0] pushData,
  input wire pop,
  // State
  output reg [1:0] count,
  output wire [`ENT_W-1:0] headData
);
  reg [`ENT_W-1:0] entry [0:1];
  reg wrPtr;
  reg rdPtr;
  wire doPush = push && (count != `FIFO_DEPTH);
  wire doPop = pop && (count != 2'h0);

  assign headData = entry[rdPtr];

  genvar i;
  generate
    for (i = 0; i < `FIFO_DEPTH; i = i + 1) begin : slot
      always @(posedge clk_sys) begin
        if (rst) begin
          entry[i] <= {`ENT_W{1'b0}};
        end else if (doPush && !flush && wrPtr == i) begin
          entry[i] <= pushData;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (rst || flush) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (doPush) begin
        wrPtr <= ~wrPtr;
      end
      if (doPop) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + {1'b0, doPush} - {1'b0, doPop};
    end
  end
endmodule

// ==== design/uart_receive_buffer_flags.v ====
// Receive shift logic, frame buffer, status flags and AHB-Lite register slave.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "uart_rx_map.vh"
module uart_receive_buffer_flags (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Voted bits from the recovery unit
  input wire startDetect,
  input wire bitStrobe,
  input wire bitValue,
  // System
  input wire globalIrqEnable,
  output reg rxPinOverride,
  output reg rxcIrq
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_DATA = 4'b0010;
  localparam ST_PAR = 4'b0100;
  localparam ST_STOP = 4'b1000;

  // Software-visible control.
  reg receiveCompleteIrqEnable;
  reg receiverEnable;
  reg [2:0] charSizeField;
  reg stopBitsSelect;
  reg parityEnableBit;
  reg parityOddSelect;

  // Bus data phase state.
  reg dataPhase;
  reg dataPhaseWrite;
  reg [`ADDR_W-1:0] dataPhaseAddr;

  // Receive shift state.
  reg [3:0] state;
  reg [3:0] bitCount;
  reg [8:0] shiftReg;
  reg parityBit;
  reg frameWaiting;
  reg [`ENT_W-1:0] waitingEntry;

  wire [1:0] fifoCount;
  wire [`ENT_W-1:0] head;
  wire receiveCompleteFlag = (fifoCount != 2'h0);
  wire fifoFull = (fifoCount == `FIFO_DEPTH);

  wire addrPhase = hsel && hready && htrans[1];
  wire [`ADDR_W-1:0] addrLow = haddr[`ADDR_W-1:0];
  wire readData = addrPhase && !hwrite && addrLow == `ADDR_DATA;
  wire writeCycle = dataPhase && dataPhaseWrite;

  wire [3:0] dataBits = (charSizeField == `SIZE_NINE) ? `BITS_MAX :
                        (`SIZE_BASE + {2'b00, charSizeField[1:0]});

  // Received bits arrive LSB first into the top; realign by the unused width.
  wire [3:0] alignShift = `BITS_MAX - dataBits;
  wire [8:0] alignedData = shiftReg >> alignShift;
  wire parityMismatch = ((^alignedData) ^ parityBit) != parityOddSelect;

  // Receiver enable also disables the FIFO, so a clear both drops and flushes.
  wire flush = !receiverEnable;
  wire pushNow = frameWaiting && !fifoFull;

  reg [`ENT_W-1:0] next_entry;
  reg [31:0] next_hrdata;

  rx_frame_fifo fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(flush),
    .push(pushNow),
    .pushData(waitingEntry),
    .pop(readData),
    .count(fifoCount),
    .headData(head)
  );

  // Frame entry built at the first stop bit; later stop bits are never looked at.
  always @* begin
    next_entry = {`ENT_W{1'b0}};
    next_entry[8:0] = alignedData;
    next_entry[`ENT_FE] = !bitValue;
    next_entry[`ENT_UPE] = parityEnableBit && parityMismatch;
    next_entry[`ENT_DOR] = 1'b0;
  end

  // Receive shift engine.
  always @(posedge clk_sys) begin
    if (rst || !receiverEnable) begin
      state <= ST_IDLE;
      bitCount <= 4'h0;
      shiftReg <= 9'h000;
      parityBit <= 1'b0;
      frameWaiting <= 1'b0;
      waitingEntry <= {`ENT_W{1'b0}};
    end else begin
      if (pushNow) begin
        frameWaiting <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (startDetect) begin
            if (frameWaiting && fifoFull) begin
              // The new frame is dropped; the loss is marked on the waiting frame.
              waitingEntry[`ENT_DOR] <= 1'b1;
            end else begin
              state <= ST_DATA;
              bitCount <= 4'h0;
              shiftReg <= 9'h000;
            end
          end
        end
        ST_DATA: begin
          if (bitStrobe) begin
            shiftReg <= {bitValue, shiftReg[8:1]};
            bitCount <= bitCount + 4'h1;
            if (bitCount + 4'h1 == dataBits) begin
              state <= parityEnableBit ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (bitStrobe) begin
            parityBit <= bitValue;
            state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (bitStrobe) begin
            waitingEntry <= next_entry;
            frameWaiting <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data for the address phase, registered into the data phase.
  always @* begin
    next_hrdata = 32'h00000000;
    case (addrLow)
      `ADDR_DATA: begin
        next_hrdata[7:0] = head[7:0];
      end
      `ADDR_STATUS: begin
        next_hrdata[`ST_RXC] = receiveCompleteFlag;
        next_hrdata[`ST_FE] = receiveCompleteFlag && head[`ENT_FE];
        next_hrdata[`ST_DOR] = receiveCompleteFlag && head[`ENT_DOR];
        next_hrdata[`ST_UPE] = receiveCompleteFlag && head[`ENT_UPE]
                               && parityEnableBit;
      end
      `ADDR_CONTROL: begin
        next_hrdata[`CT_IRQ_EN] = receiveCompleteIrqEnable;
        next_hrdata[`CT_RX_EN] = receiverEnable;
        next_hrdata[`CT_NINTH] = receiveCompleteFlag && head[`ENT_NINTH];
      end
      `ADDR_FORMAT: begin
        next_hrdata[`FMT_PAR_EN] = parityEnableBit;
        next_hrdata[`FMT_PAR_ODD] = parityOddSelect;
        next_hrdata[`FMT_STOP_SEL] = stopBitsSelect;
        next_hrdata[`FMT_SIZE_HI:`FMT_SIZE_LO] = charSizeField;
      end
      default: begin
        next_hrdata = 32'h00000000;
      end
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always @(posedge clk_sys) begin
    if (rst) begin
      dataPhase <= 1'b0;
      dataPhaseWrite <= 1'b0;
      dataPhaseAddr <= {`ADDR_W{1'b0}};
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        dataPhase <= addrPhase;
        dataPhaseWrite <= hwrite;
        dataPhaseAddr <= addrLow;
      end
      if (addrPhase && !hwrite) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // Register writes; the status register holds no writable bit at all.
  always @(posedge clk_sys) begin
    if (rst) begin
      receiveCompleteIrqEnable <= 1'b0;
      receiverEnable <= 1'b0;
      charSizeField <= `SIZE_RESET;
      stopBitsSelect <= 1'b0;
      parityEnableBit <= 1'b0;
      parityOddSelect <= 1'b0;
    end else if (writeCycle) begin
      // A status write falls through here and changes nothing.
      case (dataPhaseAddr)
        `ADDR_CONTROL: begin
          receiveCompleteIrqEnable <= hwdata[`CT_IRQ_EN];
          receiverEnable <= hwdata[`CT_RX_EN];
        end
        `ADDR_FORMAT: begin
          parityEnableBit <= hwdata[`FMT_PAR_EN];
          parityOddSelect <= hwdata[`FMT_PAR_ODD];
          stopBitsSelect <= hwdata[`FMT_STOP_SEL];
          charSizeField <= hwdata[`FMT_SIZE_HI:`FMT_SIZE_LO];
        end
        default: begin
          receiverEnable <= receiverEnable;
        end
      endcase
    end
  end

  // Pin override and interrupt level; error flags take no part in the request.
  always @(posedge clk_sys) begin
    if (rst) begin
      rxPinOverride <= 1'b0;
      rxcIrq <= 1'b0;
    end else begin
      rxPinOverride <= receiverEnable;
      rxcIrq <= receiveCompleteIrqEnable && globalIrqEnable
                && receiveCompleteFlag;
    end
  end
endmodule

// ==== tb/serial_sender.sv ====
// Model of the remote transmitter, handing voted bits to the receiver.
`timescale 1ns/1ns
module serial_sender (
  // Clock
  input wire clk_sys,
  // Voted bits
  output reg startDetect = 1'b0,
  output reg bitStrobe = 1'b0,
  output reg bitValue = 1'b1
);
  integer i;
  // Between strobes the value is inverted, so the receiver cannot lean on a stale level.
  task put(input b, input integer gap);
    begin
      bitStrobe <= 1'b1;
      bitValue <= b;
      @(posedge clk_sys);
      bitStrobe <= 1'b0;
      bitValue <= ~b;
      repeat (gap) @(posedge clk_sys);
    end
  endtask
  task send(input [8:0] d, input integer n, input par, input pb, input stp, input whole,
    input integer gap);
    begin
      @(posedge clk_sys);
      startDetect <= 1'b1;
      @(posedge clk_sys);
      startDetect <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        put(d[i], gap);
      end
      if (par) begin
        put(pb, gap);
      end
      if (whole) begin
        put(stp, gap);
      end
    end
  endtask
endmodule

// ==== tb/uart_rx_checker_assertions.sv ====
// Port checker for the receive buffer block.
`timescale 1ns/1ns
module uart_rx_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // System
  input wire globalIrqEnable,
  input wire rxPinOverride,
  input wire rxcIrq
);
  reg aValid;
  reg aWrite;
  reg [3:0] aAddr;
  reg ctlSeen;
  reg ctlEn;
  reg fmtPar;
  always @(posedge clk_sys) begin
    if (rst) begin
      aValid <= 1'b0;
      ctlSeen <= 1'b0;
      fmtPar <= 1'b0;
    end else begin
      aValid <= hsel && hready && htrans[1];
      aWrite <= hwrite;
      aAddr <= haddr[3:0];
      ctlSeen <= aValid && aWrite && aAddr == 4'h8;
      if (aValid && aWrite && aAddr == 4'h8) begin
        ctlEn <= hwdata[4];
      end
      if (aValid && aWrite && aAddr == 4'hC) begin
        fmtPar <= hwdata[5];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence statusRd;
    aValid && !aWrite && aAddr == 4'h4;
  endsequence
  sequence dataRd;
    aValid && !aWrite && aAddr == 4'h0;
  endsequence
  sequence rxOff;
    ctlSeen && !ctlEn;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  data_upper_a: assert property (dataRd |-> hrdata[31:8] == 24'h0)
    else $error("data read upper bits set");
  empty_flags_a: assert property (statusRd |-> hrdata[7] || hrdata[4:2] == 3'h0)
    else $error("error flags with empty buffer");
  flushed_empty_a: assert property (statusRd ##0 !$past(rxPinOverride) |-> !hrdata[7])
    else $error("data shown while disabled");
  parity_off_a: assert property (statusRd ##0 !$past(fmtPar) |-> !hrdata[2])
    else $error("parity error with checking off");
  irq_gate_a: assert property (rxcIrq |-> $past(globalIrqEnable))
    else $error("interrupt without global enable");
  pin_follow_a: assert property (ctlSeen |-> ##[0:1] rxPinOverride == ctlEn)
    else $error("pin override not following enable");
  // The enable lands one cycle before the flush, and the request is registered after it.
  off_quiet_a: assert property (rxOff |-> ##2 !rxcIrq)
    else $error("interrupt after disable");
endmodule
bind uart_receive_buffer_flags uart_rx_checker chk_u (.clk_sys(clk_sys), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .globalIrqEnable(globalIrqEnable), .rxPinOverride(rxPinOverride), .rxcIrq(rxcIrq));

// ==== tb/tb.sv ====
// Self-checking bench for the receive buffer block.
`timescale 1ns/1ns
module tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg globalIrqEnable = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire startDetect;
  wire bitStrobe;
  wire bitValue;
  wire rxPinOverride;
  wire rxcIrq;
  integer err_total = 0;
  integer check_count = 0;
  integer k;
  reg [31:0] rd;
  always #5 clk_sys = ~clk_sys;
  uart_receive_buffer_flags dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .startDetect(startDetect),
    .bitStrobe(bitStrobe), .bitValue(bitValue), .globalIrqEnable(globalIrqEnable),
    .rxPinOverride(rxPinOverride), .rxcIrq(rxcIrq));
  serial_sender tx_u (.clk_sys(clk_sys), .startDetect(startDetect), .bitStrobe(bitStrobe),
    .bitValue(bitValue));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {28'h0, a};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
    end
  endtask
  task rdchk(input [3:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge clk_sys);
      #1;
    end
  endtask
  // Status and ninth bit are read before data, since the data read moves the buffer on.
  task frame(input [7:0] fmt, input [8:0] d, input pb, input stp, input [7:0] st,
    input [8:0] ex);
    begin
      bus(1'b1, 4'hC, {24'h0, fmt});
      tx_u.send(d, fmt[2:0] == 3'h7 ? 9 : 5 + fmt[1:0], fmt[5], pb, stp, 1'b1, 2);
      settle;
      rdchk(4'h4, {24'h0, st});
      rdchk(4'h8, {24'h0, 6'h24, ex[8], 1'b0});
      rdchk(4'h0, {24'h0, ex[7:0]});
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  initial begin
    #400000;
    err_total = err_total + 1;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(4'h4, 32'h0);
    rdchk(4'hC, 32'h3);
    bus(1'b1, 4'h8, 32'h90);
    settle;
    check({31'h0, rxPinOverride}, 32'h1);
    tx_u.send(9'h0A5, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
    settle;
    check({31'h0, rxcIrq}, 32'h0);
    @(posedge clk_sys);
    globalIrqEnable <= 1'b1;
    settle;
    rdchk(4'h4, 32'h80);
    check({31'h0, rxcIrq}, 32'h1);
    rdchk(4'h0, 32'hA5);
    settle;
    check({31'h0, rxcIrq}, 32'h0);
    $display("test single frame done");
    for (k = 0; k < 4; k = k + 1) begin
      tx_u.send(9'h011 * (k + 1), 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
    end
    settle;
    for (k = 0; k < 3; k = k + 1) begin
      rdchk(4'h4, k == 2 ? 32'h88 : 32'h80);
      rdchk(4'h0, 32'h11 * (k + 1));
    end
    rdchk(4'h4, 32'h0);
    frame(8'h03, 9'h055, 1'b0, 1'b1, 8'h80, 9'h055);
    $display("test overrun done");
    frame(8'h0B, 9'h055, 1'b0, 1'b0, 8'h90, 9'h055);
    frame(8'h23, 9'h007, 1'b1, 1'b1, 8'h80, 9'h007);
    frame(8'h23, 9'h007, 1'b0, 1'b1, 8'h84, 9'h007);
    frame(8'h33, 9'h007, 1'b0, 1'b1, 8'h80, 9'h007);
    frame(8'h33, 9'h007, 1'b1, 1'b1, 8'h84, 9'h007);
    frame(8'h00, 9'h1FF, 1'b0, 1'b1, 8'h80, 9'h01F);
    frame(8'h01, 9'h1FF, 1'b0, 1'b1, 8'h80, 9'h03F);
    frame(8'h06, 9'h1FF, 1'b0, 1'b1, 8'h80, 9'h07F);
    frame(8'h07, 9'h1A5, 1'b0, 1'b1, 8'h80, 9'h1A5);
    $display("test formats done");
    bus(1'b1, 4'hC, 32'h3);
    tx_u.send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1, 3);
    settle;
    bus(1'b1, 4'h4, 32'h0);
    rdchk(4'h4, 32'h90);
    tx_u.send(9'h00F, 4, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    bus(1'b1, 4'h8, 32'h80);
    settle;
    check({30'h0, rxPinOverride, rxcIrq}, 32'h0);
    rdchk(4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'h90);
    tx_u.send(9'h03C, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
    settle;
    rdchk(4'h4, 32'h80);
    rdchk(4'h0, 32'h3C);
    $display("test disable done");
    close_out;
  end
endmodule
